// File: include/eppce_pkg.sv
// Purpose: shared constants and types of the parallel port cycle engine
// Assumes: 20 MHz system clock
// Notes:   offsets are byte offsets from the port base

package eppce_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [2:0] OFF_DATA     = 3'h0;
	localparam logic [2:0] OFF_STATUS   = 3'h1;
	localparam logic [2:0] OFF_CONTROL  = 3'h2;
	localparam logic [2:0] OFF_ADDR_WIN = 3'h3;
	localparam logic [2:0] OFF_DATA_W0  = 3'h4;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CTL_STROBE_BIT   = 0;
	localparam int unsigned CTL_LINE_FEED    = 1;
	localparam int unsigned CTL_INIT_BIT     = 2;
	localparam int unsigned CTL_SELECT_BIT   = 3;
	localparam int unsigned CTL_DIR_SELECT   = 5;
	localparam logic [7:0]  CTL_WRITE_MASK   = 8'h3f;
	localparam logic [7:0]  CTL_RESET        = 8'h00;
	localparam int unsigned STS_TIMEOUT_BIT  = 0;
	localparam logic [7:0]  BYTE_RESET       = 8'h00;

	// ----------------------------------------------------------------
	// host sync codes
	// ----------------------------------------------------------------
	localparam logic [3:0] SYNC_READY     = 4'h0;
	localparam logic [3:0] SYNC_LONG_WAIT = 4'h6;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 20000000;
	localparam int unsigned WDOG_TIME_NS  = 10000;
	localparam int unsigned WDOG_CYCLES   = (WDOG_TIME_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int unsigned SYNC_STAGES   = 2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_PRINTER = 2'h0,
		MODE_BIDIR   = 2'h1,
		MODE_EPP     = 2'h2,
		MODE_ECP     = 2'h3
	} eppce_mode_e;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'b00001,
		ST_ARM    = 5'b00010,
		ST_SETUP  = 5'b00100,
		ST_STROBE = 5'b01000,
		ST_DONE   = 5'b10000
	} eppce_state_e;

	typedef struct packed {
		logic       wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} eppce_io_req_s;

endpackage

// File: hdl/eppce_sync.sv
// Purpose: two-stage synchroniser for the cable inputs
// Assumes: inputs are asynchronous to clk_i
// Notes:   first stage is read only by the second stage

module eppce_sync #(
	parameter int unsigned WIDTH = 9
) (
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule

// File: hdl/eppce_engine.sv
// Purpose: parallel port cycle engine turning host i/o accesses into cable handshakes
// Assumes: host accesses arrive as one-cycle requests; answer is a sync stream
// Notes:   printer status bits 3..7 and ecp mode are not handled here

module eppce_engine
	import eppce_pkg::*;
#(
	parameter int unsigned WDOG_LIMIT = WDOG_CYCLES
) (
	input  wire logic          clk_i,
	input  wire logic          rstn_i,
	input  wire logic          io_req_i,
	input  eppce_io_req_s      io_cmd_i,
	input  wire logic [1:0]    mode_i,
	input  wire logic          variant_19_i,
	input  wire logic          timeout_select_i,
	input  wire logic          peripheral_wait_line_i,
	input  wire logic [7:0]    cable_bus_i,
	output logic [7:0]         cable_bus_o,
	output logic               cable_bus_oe_o,
	output logic               write_indicator_n_o,
	output logic               data_phase_select_n_o,
	output logic               address_phase_select_n_o,
	output logic               init_n_o,
	output logic               bus_direction_flag_o,
	output logic               timeout_flag_o,
	output logic               io_sync_valid_o,
	output logic [3:0]         io_sync_o,
	output logic [7:0]         io_rdata_o,
	output logic               io_tar_o
);

	initial begin
		if (WDOG_LIMIT < 2 || WDOG_LIMIT > 65535) begin
			$error("watchdog limit out of range");
		end
	end

	// ----------------------------------------------------------------
	// cable input synchronisers
	// ----------------------------------------------------------------
	logic [8:0] pins_s;
	eppce_sync #(.WIDTH(9)) u_sync (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.async_i ({peripheral_wait_line_i, cable_bus_i}),
		.sync_o  (pins_s)
	);
	wire       wait_high = pins_s[8];
	wire [7:0] bus_in    = pins_s[7:0];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	eppce_state_e  state_r, state_nxt;
	logic [7:0]    ctrl_r, data_r, addr_win_r, dwin_r, rdata_r;
	logic          hs_write_r, hs_addr_r, timeout_r, abort_r;
	logic [15:0]   wdog_r;

	wire epp_mode   = (mode_i == MODE_EPP);
	wire win_hit    = io_cmd_i.addr >= OFF_ADDR_WIN;
	wire start_hs   = io_req_i && (state_r == ST_IDLE) && win_hit && epp_mode;
	wire quick_acc  = io_req_i && (state_r == ST_IDLE) && !start_hs;
	wire dir_in     = ctrl_r[CTL_DIR_SELECT];
	// a write with the direction bit set becomes a read-like cycle, silently
	wire hs_wr_dir  = io_cmd_i.wr && !dir_in;
	wire force_wr   = ctrl_r[CTL_STROBE_BIT];
	wire in_hs      = (state_r == ST_SETUP) || (state_r == ST_STROBE);
	wire wdog_on    = (state_r == ST_ARM) || (state_r == ST_STROBE) || (state_r == ST_SETUP);
	wire wdog_fire  = wdog_on && (wdog_r >= 16'(WDOG_LIMIT));
	wire hs_done    = (state_r == ST_STROBE) && wait_high;

	// ----------------------------------------------------------------
	// handshake sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_hs) begin
					state_nxt = variant_19_i ? ST_ARM : ST_SETUP;
				end else if (quick_acc) begin
					state_nxt = ST_DONE;
				end
			end
			ST_ARM: begin
				// wait high at start: hold everything until the peripheral pulls it low
				if (wdog_fire) begin
					state_nxt = ST_DONE;
				end else if (!wait_high) begin
					state_nxt = ST_SETUP;
				end
			end
			ST_SETUP: begin
				state_nxt = wdog_fire ? ST_DONE : ST_STROBE;
			end
			ST_STROBE: begin
				if (wdog_fire || hs_done) begin
					state_nxt = ST_DONE;
				end
			end
			ST_DONE: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// pin drive: idle follows mode and the control and data registers, handshake overrides
	// ----------------------------------------------------------------
	wire       idle_out   = (mode_i == MODE_PRINTER) || !dir_in;
	wire       hs_out     = hs_write_r || force_wr;
	wire       oe_nxt     = in_hs ? hs_out : idle_out;
	wire [7:0] hs_byte    = hs_addr_r ? addr_win_r : dwin_r;
	wire [7:0] bus_nxt    = in_hs ? hs_byte : data_r;
	wire       wr_n_nxt   = in_hs ? !hs_out : !ctrl_r[CTL_STROBE_BIT];
	wire       strobe_on  = (state_nxt == ST_STROBE);
	wire       dstb_n_nxt = strobe_on && !hs_addr_r ? 1'b0
	                      : (in_hs || strobe_on) ? 1'b1 : !ctrl_r[CTL_LINE_FEED];
	wire       astb_n_nxt = strobe_on && hs_addr_r ? 1'b0
	                      : (in_hs || strobe_on) ? 1'b1 : !ctrl_r[CTL_SELECT_BIT];

	// ----------------------------------------------------------------
	// quick register reads
	// ----------------------------------------------------------------
	logic [7:0] quick_rd;
	assign quick_rd = (io_cmd_i.addr == OFF_DATA)    ? bus_in
	                : (io_cmd_i.addr == OFF_STATUS)  ? {7'h00, timeout_r}
	                : (io_cmd_i.addr == OFF_CONTROL) ? (ctrl_r & CTL_WRITE_MASK)
	                : 8'h00;

	wire sts_write = quick_acc && io_cmd_i.wr && (io_cmd_i.addr == OFF_STATUS);
	wire sts_read  = quick_acc && !io_cmd_i.wr && (io_cmd_i.addr == OFF_STATUS);
	wire to_clear  = timeout_select_i ? sts_read
	                                  : (sts_write && io_cmd_i.wdata[STS_TIMEOUT_BIT]);
	wire timeout_nxt = wdog_fire || (timeout_r && !to_clear);                      // set wins over clear

	// ----------------------------------------------------------------
	// control, data and window registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ctrl_r     <= CTL_RESET;
			data_r     <= BYTE_RESET;
			addr_win_r <= BYTE_RESET;
			dwin_r     <= BYTE_RESET;
			hs_write_r <= 1'b0;
			hs_addr_r  <= 1'b0;
			timeout_r  <= 1'b0;
		end else begin
			timeout_r <= timeout_nxt;
			if (quick_acc && io_cmd_i.wr && io_cmd_i.addr == OFF_CONTROL) begin
				ctrl_r <= io_cmd_i.wdata & CTL_WRITE_MASK;
			end
			if (quick_acc && io_cmd_i.wr && io_cmd_i.addr == OFF_DATA) begin
				data_r <= io_cmd_i.wdata;
			end
			if (start_hs) begin
				hs_write_r <= hs_wr_dir;
				hs_addr_r  <= (io_cmd_i.addr == OFF_ADDR_WIN);
				if (io_cmd_i.wr && io_cmd_i.addr == OFF_ADDR_WIN) begin
					addr_win_r <= io_cmd_i.wdata;
				end
				if (io_cmd_i.wr && io_cmd_i.addr >= OFF_DATA_W0) begin
					dwin_r <= io_cmd_i.wdata;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// watchdog and read capture
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_r <= ST_IDLE;
			wdog_r  <= 16'h0000;
			abort_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			wdog_r  <= wdog_on ? wdog_r + 16'h0001 : 16'h0000;
			abort_r <= wdog_fire;
			if (hs_done && !hs_out) begin
				rdata_r <= bus_in;
			end else if (quick_acc && !io_cmd_i.wr) begin
				rdata_r <= quick_rd;
			end
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cable_bus_o              <= 8'h00;
			cable_bus_oe_o           <= 1'b1;
			write_indicator_n_o      <= 1'b1;
			data_phase_select_n_o    <= 1'b1;
			address_phase_select_n_o <= 1'b1;
			init_n_o                 <= 1'b0;
			bus_direction_flag_o     <= 1'b0;
			timeout_flag_o           <= 1'b0;
			io_sync_valid_o          <= 1'b0;
			io_sync_o                <= SYNC_READY;
			io_tar_o                 <= 1'b0;
		end else begin
			cable_bus_o              <= bus_nxt;
			cable_bus_oe_o           <= oe_nxt;
			write_indicator_n_o      <= wr_n_nxt;
			data_phase_select_n_o    <= dstb_n_nxt;
			address_phase_select_n_o <= astb_n_nxt;
			init_n_o                 <= ctrl_r[CTL_INIT_BIT];
			bus_direction_flag_o     <= !oe_nxt;
			timeout_flag_o           <= timeout_nxt;
			// long wait while the handshake runs, ready once it is done or aborted
			// taken from the next state so the first wait sync stands one cycle after the request
			io_sync_valid_o          <= (state_nxt != ST_IDLE);
			io_sync_o                <= (state_nxt == ST_DONE) ? SYNC_READY : SYNC_LONG_WAIT;
			io_tar_o                 <= (state_r == ST_DONE);
		end
	end

	assign io_rdata_o = rdata_r;

endmodule

// File: sim/eppce_peripheral.sv
// Purpose: behavioural cable peripheral for the cycle engine bench
// Assumes: strobes stay high outside handshakes
// Notes:   lag_i of ff never releases wait, so the watchdog fires
module eppce_peripheral (
	input  wire logic       clk_i,
	input  wire logic       dsel_n_i,
	input  wire logic       asel_n_i,
	input  wire logic       write_n_i,
	input  wire logic [7:0] bus_i,
	input  wire logic [7:0] rd_byte_i,
	input  wire logic [7:0] lag_i,
	input  wire logic       park_hi_i,
	output logic            wait_n_o,
	output logic [7:0]      bus_o,
	output logic [7:0]      got_o,
	output logic            got_addr_o,
	output logic [7:0]      n_hs_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       drive, act, act_q;
	logic [7:0] cnt;
	// ----
	// handshake
	// ----
	assign act   = !dsel_n_i || !asel_n_i;
	// a released bus shows the inverse, so a late capture cannot match
	assign bus_o = drive ? rd_byte_i : ~rd_byte_i;
	initial begin
		{wait_n_o, drive, act_q, cnt, got_o, got_addr_o, n_hs_o} = '0;
	end
	always @(posedge clk_i) begin
		act_q <= act;
		if (act) begin
			cnt <= cnt + 8'h01;
			got_addr_o <= !asel_n_i;
			if (!write_n_i) got_o <= bus_i;
			drive <= write_n_i;
			if (cnt >= lag_i && drive == write_n_i && lag_i != 8'hff) wait_n_o <= 1'b1;
		end else begin
			cnt <= 8'h00;
			drive <= 1'b0;
			wait_n_o <= park_hi_i || act_q;
			if (act_q) n_hs_o <= n_hs_o + 8'h01;
		end
	end
endmodule

// File: sim/eppce_engine_monitor.sv
// Purpose: port checks of the cycle engine
// Assumes: one clock, synchronous active-low reset
// Notes:   hs marks a running cable handshake
module eppce_engine_monitor
	import eppce_pkg::*;
#(
	parameter int unsigned WDOG_LIMIT = WDOG_CYCLES
) (
	input wire logic          clk_i,
	input wire logic          rstn_i,
	input wire logic          io_req_i,
	input wire eppce_io_req_s io_cmd_i,
	input wire logic [1:0]    mode_i,
	input wire logic          variant_19_i,
	input wire logic          timeout_select_i,
	input wire logic          peripheral_wait_line_i,
	input wire logic [7:0]    cable_bus_i,
	input wire logic [7:0]    cable_bus_o,
	input wire logic          cable_bus_oe_o,
	input wire logic          write_indicator_n_o,
	input wire logic          data_phase_select_n_o,
	input wire logic          address_phase_select_n_o,
	input wire logic          init_n_o,
	input wire logic          bus_direction_flag_o,
	input wire logic          timeout_flag_o,
	input wire logic          io_sync_valid_o,
	input wire logic [3:0]    io_sync_o,
	input wire logic [7:0]    io_rdata_o,
	input wire logic          io_tar_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       take, rdy, hs, stb;
	logic [9:0] hs_cnt_r;
	assign take = io_req_i && !io_sync_valid_o && !io_tar_o;
	assign rdy  = io_sync_valid_o && io_sync_o == SYNC_READY;
	assign hs   = io_sync_valid_o && io_sync_o == SYNC_LONG_WAIT;
	assign stb  = !data_phase_select_n_o || !address_phase_select_n_o;
	// counts wait syncs so a stuck watchdog shows as an overrun
	always_ff @(posedge clk_i) hs_cnt_r <= hs ? hs_cnt_r + 10'h001 : 10'h000;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// ----
	// checks
	// ----
	quick_ready_a: assert property (take && (mode_i != MODE_EPP || io_cmd_i.addr < OFF_ADDR_WIN) |=> rdy)
		else $error("quick access not ready");
	long_wait_a: assert property (take && mode_i == MODE_EPP && io_cmd_i.addr >= OFF_ADDR_WIN |=> hs)
		else $error("handshake without wait sync");
	tar_follow_a: assert property (rdy |=> io_tar_o && !io_sync_valid_o)
		else $error("no turnaround after ready");
	wr_drive_a: assert property (hs && stb && !write_indicator_n_o |-> cable_bus_oe_o)
		else $error("write strobe on undriven bus");
	rd_float_a: assert property (hs && stb && write_indicator_n_o |-> !cable_bus_oe_o && bus_direction_flag_o)
		else $error("read strobe on driven bus");
	strobe_armed_a: assert property (variant_19_i && hs && $rose(stb) |-> $past(peripheral_wait_line_i, 2) == 1'b0)
		else $error("strobe before wait asserted");
	wdog_bound_a: assert property (hs_cnt_r <= WDOG_LIMIT + 8)
		else $error("wait syncs beyond watchdog");
	rdata_hold_a: assert property ($changed(io_rdata_o) |-> rdy)
		else $error("read byte changed outside ready");
	cover property (hs ##1 rdy);
	cover property ($rose(timeout_flag_o));
	cover property (hs && !address_phase_select_n_o);
endmodule

bind eppce_engine eppce_engine_monitor #(.WDOG_LIMIT(WDOG_LIMIT)) mon (.*);

// File: sim/eppce_engine_tb.sv
// Purpose: self-checking bench of the cycle engine
// Assumes: watchdog shortened to WD cycles
// Notes:   inputs move on the falling edge
module eppce_engine_tb
	import eppce_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned WD = 40;
	typedef struct packed {logic v; logic [7:0] c; logic w; logic [2:0] a; logic [7:0] d;} eppce_row_s;
	eppce_row_s    rows [7];
	eppce_io_req_s cmd;
	logic          clk, rstn, req, v19, tsel, park, wt, oe, wn, dn, an, ini, dir, tmo, sv, tar, ga;
	logic [1:0]    mode;
	logic [3:0]    sy;
	logic [7:0]    bi, pb, bo, rdb, lag, got, nhs, rdq, rd, k;
	int            num_errors, n_checks, cyc, lat;
	eppce_engine #(.WDOG_LIMIT(WD)) DUT (.clk_i(clk), .rstn_i(rstn), .io_req_i(req), .io_cmd_i(cmd), .mode_i(mode),
		.variant_19_i(v19), .timeout_select_i(tsel), .peripheral_wait_line_i(wt), .cable_bus_i(bi), .cable_bus_o(bo),
		.cable_bus_oe_o(oe), .write_indicator_n_o(wn), .data_phase_select_n_o(dn), .address_phase_select_n_o(an),
		.init_n_o(ini), .bus_direction_flag_o(dir), .timeout_flag_o(tmo), .io_sync_valid_o(sv), .io_sync_o(sy),
		.io_rdata_o(rd), .io_tar_o(tar));
	eppce_peripheral PER (.clk_i(clk), .dsel_n_i(dn), .asel_n_i(an), .write_n_i(wn), .bus_i(bi), .rd_byte_i(rdb),
		.lag_i(lag), .park_hi_i(park), .wait_n_o(wt), .bus_o(pb), .got_o(got), .got_addr_o(ga), .n_hs_o(nhs));
	assign bi = oe ? bo : pb;
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one host access; waits for the ready sync under a bound
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(negedge clk);
		req = 1'b1;
		cmd = '{wr: w, addr: a, wdata: d};
		@(negedge clk);
		req = 1'b0;
		lat = 0;
		while (!(sv === 1'b1 && sy === SYNC_READY) && lat < 400) begin
			@(negedge clk);
			lat++;
		end
		rdq = rd;
		@(negedge clk);
		chk("turnaround", {7'h0, tar}, 8'h01);
		@(negedge clk);
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		rows = '{'{1, 8'h04, 1, 3'h3, 8'ha5}, '{1, 8'h04, 1, 3'h4, 8'h3c}, '{1, 8'h04, 1, 3'h7, 8'h81},
			'{1, 8'h04, 0, 3'h3, 8'h5a}, '{1, 8'h04, 0, 3'h6, 8'hc3}, '{0, 8'h04, 1, 3'h5, 8'h7e},
			'{0, 8'h24, 0, 3'h4, 8'h99}};
		{clk, rstn, req, v19, tsel, park, cmd, rdb, num_errors, n_checks, cyc} = '0;
		mode = MODE_EPP;
		lag = 8'h02;
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		foreach (rows[i]) begin
			v19 = rows[i].v;
			rdb = rows[i].d;
			acc(1'b1, OFF_CONTROL, rows[i].c);
			acc(rows[i].w, rows[i].a, rows[i].d);
			chk("byte", rows[i].w ? got : rdq, rows[i].d);
			chk("addr strobe", {7'h0, ga}, {7'h0, rows[i].a == OFF_ADDR_WIN});
		end
		// ----
		// awkward cases
		// ----
		v19 = 1'b1;
		lag = 8'h08;
		acc(1'b1, OFF_CONTROL, 8'h05);
		fork
			acc(1'b0, 3'h4, 8'h00);
			begin
				repeat (6) @(negedge clk);
				chk("forced write", {6'h0, wn, oe}, 8'h01);
			end
		join
		k = got;
		acc(1'b1, OFF_CONTROL, 8'h24);
		acc(1'b1, 3'h4, 8'h3e);
		chk("no write", {got[7:1], tmo}, {k[7:1], 1'b0});
		lag = 8'h00;
		park = 1'b1;
		acc(1'b1, OFF_CONTROL, 8'h04);
		fork
			acc(1'b1, 3'h5, 8'h6c);
			begin
				repeat (12) @(negedge clk);
				chk("parked", {3'h0, dn, wn, sy}, {3'h0, 2'b11, SYNC_LONG_WAIT});
				park = 1'b0;
			end
		join
		chk("late write", got, 8'h6c);
		lag = 8'hff;
		acc(1'b1, 3'h4, 8'h11);
		chk("abort", {6'h0, tmo, lat >= WD - 4 && lat <= WD + 8}, 8'h03);
		acc(1'b1, OFF_STATUS, 8'h00);
		chk("zero keeps", {7'h0, tmo}, 8'h01);
		acc(1'b1, OFF_STATUS, 8'h01);
		chk("one clears", {7'h0, tmo}, 8'h00);
		{v19, tsel} = 2'b01;
		acc(1'b0, 3'h6, 8'h00);
		acc(1'b0, OFF_STATUS, 8'h00);
		chk("read clears", {6'h0, rdq[0], tmo}, 8'h02);
		acc(1'b1, OFF_CONTROL, 8'hff);
		acc(1'b0, OFF_CONTROL, 8'h00);
		chk("control", rdq, 8'h3f);
		chk("idle pins", {3'h0, ini, dn, an, wn, dir}, 8'h11);
		acc(1'b1, OFF_CONTROL, 8'h20);
		mode = MODE_PRINTER;
		repeat (3) @(negedge clk);
		chk("printer out", {6'h0, dir, oe}, 8'h01);
		mode = MODE_BIDIR;
		k = nhs;
		acc(1'b0, 3'h4, 8'h00);
		chk("no window", {dir, oe, nhs[5:0]}, {2'b10, k[5:0]});
		rstn = 1'b0;
		repeat (3) @(negedge clk);
		chk("reset", {oe, dir, tmo, sv, tar, ini, 2'h0}, 8'h80);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		acc(1'b0, OFF_CONTROL, 8'h00);
		chk("control reset", rdq, CTL_RESET);
		close_out();
	end
endmodule
